// [design/cvr_regs.sv]
// Codec control registers with Avalon-MM slave, level engine and silence indicators
//
// Functional notes
// - Playback mute bit silences the channel output
// - Silence indicator pins are active low during mute
// - Muted channel keeps output common-mode level
// - Mute follows ramp and zero-cross settings
// - Combine enabled: both mutes needed to drive both pins
// - Attenuation code equals dB, 0 to -127
// - Attenuation changes follow ramp/zero-cross bits
// - Bit 5 enables dither for 16-bit capture
// - Format bit: 0 left-justified, 1 I2S
// - Per-channel capture mute bits silence samples
// - High-pass disable holds offset, still subtracted
// - Loopback routes capture data into playback
// - Combine makes each pin AND of conditions
// - Freeze stores mix, volume and capture writes, applies all on release
// - Host control enable resets to zero
// - Low power bit resets to one
// - Low power keeps all register contents
// - Identification register read-only, part and revision
// - Ramp steps 1/8 dB, 1 dB per 8 frames
// - Zero-cross wait per channel, timeout 512-1024 samples
// - Mode pair 00 now, 01 zc, 10 ramp, 11 both
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
module cvr_regs
   import cvr_pkg::*;
#(
   parameter logic [3:0] PART_CODE = 4'h5,  // Arbitrary value
   parameter logic [3:0] REV_CODE  = 4'h2   // Arbitrary value
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [CVR_AW-1:0] avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   input  wire logic             frame_sync_clock,
   input  wire logic             left_zero_cross,
   input  wire logic             right_zero_cross,
   output logic                  left_silence_indicator_pin_n,
   output logic                  right_silence_indicator_pin_n,
   output logic [LVL_W-1:0]      left_level,
   output logic [LVL_W-1:0]      right_level,
   output logic                  left_output_silenced,
   output logic                  right_output_silenced,
   output logic                  common_mode_hold,
   output logic                  capture_dither_16bit,
   output logic                  capture_serial_format,
   output logic                  capture_mute_left,
   output logic                  capture_mute_right,
   output logic                  hpf_hold_left,
   output logic                  hpf_hold_right,
   output logic                  loopback_enable,
   output logic                  host_control_enable,
   output logic                  low_power_request
);
   if (PART_CODE > 4'hf || REV_CODE > 4'hf) begin : g_bad_id
      $error("Identity code wider than nibble");
   end

   // Register storage: shadow holds writes, active holds applied values
   logic [7:0] mix_q, lvol_q, rvol_q, cap_q, mode_q;
   logic [7:0] mix_a_q, lvol_a_q, rvol_a_q, cap_a_q;
   logic       ack_q;
   logic [2:0] fs_sync_q;
   logic       fs_tick;
   logic [2:0] zcl_sync_q, zcr_sync_q;
   logic       fs_lvl_q, zcl_lvl_q, zcr_lvl_q;

   // Bus decode
   wire        req        = (avs_read | avs_write) & ~ack_q;
   wire        wr_en      = avs_write & ~ack_q & avs_byteenable[0];
   wire [7:0]  wd         = avs_writedata[7:0];
   wire        hit_mix    = avs_address == IDX_MIXCTL;
   wire        hit_lvol   = avs_address == IDX_LVOL;
   wire        hit_rvol   = avs_address == IDX_RVOL;
   wire        hit_cap    = avs_address == IDX_CAPCTL;
   wire        hit_mode   = avs_address == IDX_MODE2;
   wire        hit_id     = avs_address == IDX_PARTID;
   wire        freeze     = mode_q[B_FREEZE];
   wire [7:0]  rd_mux     = hit_mix  ? mix_q  :
                            hit_lvol ? lvol_q :
                            hit_rvol ? rvol_q :
                            hit_cap  ? cap_q  :
                            hit_mode ? mode_q :
                            hit_id   ? {PART_CODE, REV_CODE} :
                            8'h00;

   // One wait cycle per access; answer on the second edge of the request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_q           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         ack_q           <= req;
         avs_waitrequest <= ~req;
         avs_readdata    <= req ? {24'h00_0000, rd_mux} : avs_readdata;
      end
   end

   // Shadow registers; reserved bits masked off, identification never written
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mix_q  <= RST_MIXCTL;
         lvol_q <= RST_VOL;
         rvol_q <= RST_VOL;
         cap_q  <= RST_CAPCTL;
         mode_q <= RST_MODE2;
      end else if (wr_en) begin
         if (hit_mix)  mix_q  <= wd & MSK_MIXCTL;
         if (hit_lvol) lvol_q <= wd;
         if (hit_rvol) rvol_q <= wd;
         if (hit_cap)  cap_q  <= wd & MSK_CAPCTL;
         if (hit_mode) mode_q <= wd & MSK_MODE2;
      end
   end

   // Apply shadow to active unless frozen; low power leaves contents alone
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mix_a_q  <= RST_MIXCTL;
         lvol_a_q <= RST_VOL;
         rvol_a_q <= RST_VOL;
         cap_a_q  <= RST_CAPCTL;
      end else if (!freeze) begin
         mix_a_q  <= mix_q;
         lvol_a_q <= lvol_q;
         rvol_a_q <= rvol_q;
         cap_a_q  <= cap_q;
      end
   end

   // Pin synchronisers: change counts when stages two and three agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fs_sync_q  <= 3'h0;
         zcl_sync_q <= 3'h0;
         zcr_sync_q <= 3'h0;
         fs_lvl_q   <= 1'b0;
         zcl_lvl_q  <= 1'b0;
         zcr_lvl_q  <= 1'b0;
      end else begin
         fs_sync_q  <= {fs_sync_q[1:0], frame_sync_clock};
         zcl_sync_q <= {zcl_sync_q[1:0], left_zero_cross};
         zcr_sync_q <= {zcr_sync_q[1:0], right_zero_cross};
         fs_lvl_q   <= (fs_sync_q[1] == fs_sync_q[2]) ? fs_sync_q[2] : fs_lvl_q;
         zcl_lvl_q  <= (zcl_sync_q[1] == zcl_sync_q[2]) ? zcl_sync_q[2] : zcl_lvl_q;
         zcr_lvl_q  <= (zcr_sync_q[1] == zcr_sync_q[2]) ? zcr_sync_q[2] : zcr_lvl_q;
      end
   end
   assign fs_tick = fs_sync_q[1] & fs_sync_q[2] & ~fs_lvl_q;

   wire cvr_chg_t chg_mode = cvr_chg_t'(mix_a_q[B_SOFT:B_ZC]);
   wire zcl = zcl_sync_q[1] & zcl_sync_q[2] & ~zcl_lvl_q;
   wire zcr = zcr_sync_q[1] & zcr_sync_q[2] & ~zcr_lvl_q;

   // Targets: mute drives level to floor, else code times eight
   wire [LVL_W-1:0] tgt_l = lvol_a_q[B_MUTE] ? LVL_MUTE : {lvol_a_q[6:0], 3'h0};
   wire [LVL_W-1:0] tgt_r = rvol_a_q[B_MUTE] ? LVL_MUTE : {rvol_a_q[6:0], 3'h0};

   logic lmute_done, rmute_done;
   cvr_level u_left (
      .clk       (clk),
      .resetn    (resetn),
      .chg_mode  (chg_mode),
      .fs_tick   (fs_tick),
      .zc        (zcl),
      .target    (tgt_l),
      .level     (left_level),
      .at_floor  (lmute_done)
   );
   cvr_level u_right (
      .clk       (clk),
      .resetn    (resetn),
      .chg_mode  (chg_mode),
      .fs_tick   (fs_tick),
      .zc        (zcr),
      .target    (tgt_r),
      .level     (right_level),
      .at_floor  (rmute_done)
   );

   // Mute conditions and indicator combining
   wire lm    = lvol_a_q[B_MUTE];
   wire rm    = rvol_a_q[B_MUTE];
   wire comb  = mode_q[B_COMBINE];
   wire l_act = comb ? (lm & rm) : lm;
   wire r_act = comb ? (lm & rm) : rm;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_silence_indicator_pin_n  <= 1'b1;
         right_silence_indicator_pin_n <= 1'b1;
         left_output_silenced          <= 1'b0;
         right_output_silenced         <= 1'b0;
         common_mode_hold              <= 1'b0;
      end else begin
         left_silence_indicator_pin_n  <= ~l_act;
         right_silence_indicator_pin_n <= ~r_act;
         left_output_silenced          <= lm & lmute_done;
         right_output_silenced         <= rm & rmute_done;
         common_mode_hold              <= lm | rm;
      end
   end

   // Capture and mode outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         capture_dither_16bit  <= 1'b0;
         capture_serial_format <= 1'b0;
         capture_mute_left     <= 1'b0;
         capture_mute_right    <= 1'b0;
         hpf_hold_left         <= 1'b0;
         hpf_hold_right        <= 1'b0;
         loopback_enable       <= 1'b0;
         host_control_enable   <= 1'b0;
         low_power_request     <= 1'b1;
      end else begin
         capture_dither_16bit  <= cap_a_q[B_DITHER];
         capture_serial_format <= cap_a_q[B_CAPFMT];
         capture_mute_left     <= cap_a_q[B_CMUTE_L];
         capture_mute_right    <= cap_a_q[B_CMUTE_R];
         hpf_hold_left         <= cap_a_q[B_HPD_L];
         hpf_hold_right        <= cap_a_q[B_HPD_R];
         loopback_enable       <= mode_q[B_LOOP];
         host_control_enable   <= mode_q[B_HCEN];
         low_power_request     <= mode_q[B_LPWR];
      end
   end

   AST_RD_ONE_WAIT: assert property (@(posedge clk) disable iff (!resetn)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest)
      else $error("Read not answered after one wait cycle");
   AST_ID_READ: assert property (@(posedge clk) disable iff (!resetn)
      (avs_read && avs_waitrequest && hit_id) |=> avs_readdata[7:0] == {PART_CODE, REV_CODE})
      else $error("Identification read wrong");
   AST_RSVD_MODE: assert property (@(posedge clk) disable iff (!resetn)
      mode_q[7:5] == 3'h0)
      else $error("Reserved mode bits set");
   AST_FREEZE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      (freeze && $past(freeze)) |-> $stable(lvol_a_q))
      else $error("Active volume changed while frozen");
   AST_APPLY: assert property (@(posedge clk) disable iff (!resetn)
      !freeze |=> cap_a_q == $past(cap_q))
      else $error("Capture control not applied");
   AST_COMBINE: assert property (@(posedge clk) disable iff (!resetn)
      (comb && lm && !rm) |=> (left_silence_indicator_pin_n && right_silence_indicator_pin_n))
      else $error("Combined indicator asserted with one mute");
   AST_IND_MUTE: assert property (@(posedge clk) disable iff (!resetn)
      (!comb && lm) |=> !left_silence_indicator_pin_n)
      else $error("Left indicator not asserted on mute");
   AST_LOOP: assert property (@(posedge clk) disable iff (!resetn)
      mode_q[B_LOOP] |=> loopback_enable)
      else $error("Loopback not followed");
   AST_CM_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      lm |=> common_mode_hold)
      else $error("Common mode not held");
   AST_LPWR_KEEP: assert property (@(posedge clk) disable iff (!resetn)
      (low_power_request && !wr_en) |=> $stable(cap_q))
      else $error("Register changed in low power");

   // Bus handshake: taken with wait high, answered for one cycle, then wait again
   sequence s_bus_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_bus_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_HANDSHAKE: assert property (@(posedge clk) disable iff (!resetn)
      s_bus_taken |=> s_bus_answer)
      else $error("Bus answer not one cycle long");

   // Output followers
   AST_SILENCED: assert property (@(posedge clk) disable iff (!resetn)
      (lm && lmute_done) |=> left_output_silenced)
      else $error("Left output not silenced at floor");
   AST_IND_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
      (!lm && !rm) |=> (left_silence_indicator_pin_n && right_silence_indicator_pin_n))
      else $error("Indicator active without mute");
   AST_HCEN: assert property (@(posedge clk) disable iff (!resetn)
      mode_q[B_HCEN] |=> host_control_enable)
      else $error("Host control enable not followed");
   AST_LPWR: assert property (@(posedge clk) disable iff (!resetn)
      mode_q[B_LPWR] |=> low_power_request)
      else $error("Low power request not followed");
   AST_CAP_MUTE: assert property (@(posedge clk) disable iff (!resetn)
      cap_a_q[B_CMUTE_L] |=> capture_mute_left)
      else $error("Left capture mute not followed");
endmodule // cvr_regs

// Per-channel level engine: immediate, zero-cross, ramp or both
module cvr_level
   import cvr_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire cvr_chg_t         chg_mode,
   input  wire logic             fs_tick,
   input  wire logic             zc,
   input  wire logic [LVL_W-1:0] target,
   output logic      [LVL_W-1:0] level,
   output logic                  at_floor
);
   logic [10:0] zc_cnt_q;
   wire ramp   = chg_mode[1];
   wire zcen   = chg_mode[0];
   wire diff   = level != target;
   wire zc_ok  = !zcen || zc || (zc_cnt_q >= ZC_TIMEOUT);
   // Combined mode steps on a crossing at once, on a frame tick after timeout
   wire upd    = diff && zc_ok && (!ramp || fs_tick || (zcen && zc));
   wire [LVL_W-1:0] nxt = (level < target) ? level + 10'h001 : level - 10'h001;

   // 8 steps of 1/8 dB per 8 frames: one step per frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level    <= {LVL_W{1'b0}};
         zc_cnt_q <= 11'h000;
      end else begin
         // Timeout restarts after every applied step
         zc_cnt_q <= (!diff || zc || upd) ? 11'h000 : (fs_tick ? zc_cnt_q + 11'h001 : zc_cnt_q);
         if (upd) begin
            if (!ramp) begin
               level <= target;
            end else begin
               level <= nxt;
            end
         end
      end
   end
   assign at_floor = level == LVL_MUTE;

   // Level engine checks per change mode
   AST_NOW_MODE: assert property (@(posedge clk) disable iff (!resetn)
      (chg_mode == CVR_CHG_NOW) |=> level == $past(target))
      else $error("Immediate mode level not applied");
   AST_RAMP_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      (ramp && !fs_tick && !(zcen && zc)) |=> $stable(level))
      else $error("Ramp level moved without frame tick");
   AST_ZC_WAIT: assert property (@(posedge clk) disable iff (!resetn)
      (zcen && !zc && zc_cnt_q < ZC_TIMEOUT) |=> $stable(level))
      else $error("Level moved before crossing or timeout");
   AST_ZC_FORCE: assert property (@(posedge clk) disable iff (!resetn)
      (!ramp && zcen && diff && zc_cnt_q >= ZC_TIMEOUT) |=> level == $past(target))
      else $error("Level not forced after timeout");
endmodule // cvr_level

// [design/cvr_pkg.sv]
// Package: register map, field positions and timing constants of the codec control registers
package cvr_pkg;
   localparam int unsigned CVR_AW          = 4;
   // Register indices; byte address is four times the index
   localparam logic [3:0]  IDX_MIXCTL      = 4'h3;
   localparam logic [3:0]  IDX_LVOL        = 4'h4;
   localparam logic [3:0]  IDX_RVOL        = 4'h5;
   localparam logic [3:0]  IDX_CAPCTL      = 4'h6;
   localparam logic [3:0]  IDX_MODE2       = 4'h7;
   localparam logic [3:0]  IDX_PARTID      = 4'h8;
   localparam logic [3:0]  IDX_FRAME       = 4'h9;
   // Reset values
   localparam logic [7:0]  RST_MIXCTL      = 8'h20;
   localparam logic [7:0]  RST_VOL         = 8'h00;
   localparam logic [7:0]  RST_CAPCTL      = 8'h00;
   localparam logic [7:0]  RST_MODE2       = 8'h01;
   // Writable masks
   localparam logic [7:0]  MSK_MIXCTL      = 8'h30;
   localparam logic [7:0]  MSK_CAPCTL      = 8'h3f;
   localparam logic [7:0]  MSK_MODE2       = 8'h1f;
   // Field positions
   localparam int unsigned B_MUTE          = 7;
   localparam int unsigned B_SOFT          = 5;
   localparam int unsigned B_ZC            = 4;
   localparam int unsigned B_DITHER        = 5;
   localparam int unsigned B_CAPFMT        = 4;
   localparam int unsigned B_CMUTE_R       = 3;
   localparam int unsigned B_CMUTE_L       = 2;
   localparam int unsigned B_HPD_R         = 1;
   localparam int unsigned B_HPD_L         = 0;
   localparam int unsigned B_LOOP          = 4;
   localparam int unsigned B_COMBINE       = 3;
   localparam int unsigned B_FREEZE        = 2;
   localparam int unsigned B_HCEN          = 1;
   localparam int unsigned B_LPWR          = 0;
   // Level in 1/8 dB units: 7 bits of dB plus 3 fraction bits
   localparam int unsigned LVL_W           = 10;
   localparam logic [LVL_W-1:0] LVL_MUTE   = 10'h3ff;
   localparam logic [2:0]  RAMP_FRAMES     = 3'h0;
   localparam int unsigned ZC_TIMEOUT_MIN  = 512;
   localparam int unsigned ZC_TIMEOUT_MAX  = 1024;
   localparam logic [10:0] ZC_TIMEOUT      = 11'h200;
   typedef enum logic [1:0] {
      CVR_CHG_NOW  = 2'b00,
      CVR_CHG_ZC   = 2'b01,
      CVR_CHG_RAMP = 2'b10,
      CVR_CHG_BOTH = 2'b11
   } cvr_chg_t;
endpackage

// [verification/cvr_host.sv]
// Host model: Avalon-MM master that reads and writes the codec control registers
`timescale 1ns/1ns
module cvr_host
   import cvr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              avs_waitrequest,
   input  wire logic [31:0]       avs_readdata,
   output logic      [CVR_AW-1:0] avs_address,
   output logic                   avs_read,
   output logic                   avs_write,
   output logic      [31:0]       avs_writedata,
   output logic      [3:0]        avs_byteenable
);
   initial begin
      avs_address    = '0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'h0;
   end
   // One access held until waitrequest is seen low; ok stays clear on a hang
   task automatic xfer(input logic rd, input logic [3:0] idx, input logic [7:0] wd,
                       output logic [7:0] q, output bit ok);
      int n;
      n = 0;
      @(posedge clk);
      avs_address    <= idx;
      avs_read       <= rd;
      avs_write      <= !rd;
      avs_writedata  <= {24'h00_0000, wd};
      avs_byteenable <= 4'h1;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      q  = avs_readdata[7:0];
      ok = (avs_waitrequest === 1'b0);
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      avs_address    <= ~idx;
      avs_writedata  <= ~{24'h00_0000, wd};
      avs_byteenable <= 4'h0;
   endtask
   // Hand control to the registers and leave low power before use
   task automatic start_up(output bit ok);
      logic [7:0] q;
      xfer(1'b0, IDX_MODE2, 8'h02, q, ok);
   endtask
endmodule // cvr_host

// [verification/cvr_regs_bench.sv]
// Self-checking bench for the codec control register block
`timescale 1ns/1ns
module cvr_regs_bench;
   import cvr_pkg::*;
   localparam logic [3:0] ID_PART = 4'h9;  // Arbitrary value
   localparam logic [3:0] ID_REV  = 4'h3;  // Arbitrary value
   logic              clk, resetn, fsync, zc_l, zc_r, wreq, rq, wq;
   logic [CVR_AW-1:0] adr;
   logic [31:0]       wdat, rdat;
   logic [3:0]        be;
   logic              pin_l_n, pin_r_n, sil_l, sil_r, cm_hold, dith, fmt, cm_l, cm_r;
   logic              hpf_l, hpf_r, loop_en, hcen, lpwr;
   logic [LVL_W-1:0]  l_lvl, r_lvl;
   int                bad_count, checks;
   bit                ok;
   cvr_host host (.clk(clk), .avs_waitrequest(wreq), .avs_readdata(rdat), .avs_address(adr),
      .avs_read(rq), .avs_write(wq), .avs_writedata(wdat), .avs_byteenable(be));
   cvr_regs #(.PART_CODE(ID_PART), .REV_CODE(ID_REV)) DUT (.clk(clk), .resetn(resetn),
      .avs_address(adr), .avs_read(rq), .avs_write(wq), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .frame_sync_clock(fsync), .left_zero_cross(zc_l), .right_zero_cross(zc_r),
      .left_silence_indicator_pin_n(pin_l_n), .right_silence_indicator_pin_n(pin_r_n),
      .left_level(l_lvl), .right_level(r_lvl), .left_output_silenced(sil_l),
      .right_output_silenced(sil_r), .common_mode_hold(cm_hold), .capture_dither_16bit(dith),
      .capture_serial_format(fmt), .capture_mute_left(cm_l), .capture_mute_right(cm_r),
      .hpf_hold_left(hpf_l), .hpf_hold_right(hpf_r), .loopback_enable(loop_en),
      .host_control_enable(hcen), .low_power_request(lpwr));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] q;
      host.xfer(1'b0, idx, d, q, ok);
      chk("write handshake", 32'(ok), 32'h1);
      repeat (2) @(posedge clk);
   endtask
   task automatic rd_chk(input string what, input logic [3:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      host.xfer(1'b1, idx, 8'h00, q, ok);
      chk(what, {23'h0, ok, q}, {23'h0, 1'b1, exp});
   endtask
   task automatic await_lvl(input bit right, input logic [9:0] exp, input int lim);
      int n;
      n = 0;
      while (n < lim && (right ? r_lvl : l_lvl) !== exp) begin
         @(posedge clk);
         n++;
      end
      chk("level", 32'(right ? r_lvl : l_lvl), 32'(exp));
   endtask
   // Pulses on frame sync (0), left crossing (1) or right crossing (2)
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         @(posedge clk);
         if (which == 0) fsync <= 1'b1;
         else if (which == 1) zc_l <= 1'b1;
         else zc_r <= 1'b1;
         repeat (4) @(posedge clk);
         fsync <= 1'b0;
         zc_l <= 1'b0;
         zc_r <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic t_reset();
      chk("control enable", 32'(hcen), 32'h0);
      chk("low power", 32'(lpwr), 32'h1);
      chk("indicators", 32'({pin_l_n, pin_r_n}), 32'h3);
      rd_chk("mode reset", IDX_MODE2, 8'h01);
      rd_chk("capture reset", IDX_CAPCTL, 8'h00);
      rd_chk("mix reset", IDX_MIXCTL, 8'h20);
      wr(IDX_PARTID, 8'hff);
      rd_chk("identification", IDX_PARTID, {ID_PART, ID_REV});
      wr(4'hf, 8'h5a);
      rd_chk("unmapped", 4'hf, 8'h00);
   endtask
   task automatic t_capture();
      wr(IDX_CAPCTL, 8'hff);
      rd_chk("capture reserved", IDX_CAPCTL, 8'h3f);
      chk("capture", 32'({dith, fmt, cm_r, cm_l, hpf_r, hpf_l}), 32'h3f);
      wr(IDX_CAPCTL, 8'h15);
      chk("capture", 32'({dith, fmt, cm_r, cm_l, hpf_r, hpf_l}), 32'h15);
   endtask
   task automatic t_mode();
      host.start_up(ok);
      repeat (2) @(posedge clk);
      chk("start up", 32'({ok, hcen, lpwr}), 32'h6);
      wr(IDX_MODE2, 8'hf3);
      rd_chk("mode reserved", IDX_MODE2, 8'h13);
      chk("loopback", 32'({loop_en, lpwr}), 32'h3);
      rd_chk("kept in low power", IDX_CAPCTL, 8'h15);
      wr(IDX_MODE2, 8'h02);
      chk("loopback off", 32'({loop_en, lpwr}), 32'h0);
   endtask
   task automatic t_volume();
      wr(IDX_MIXCTL, 8'h00);
      wr(IDX_LVOL, 8'h14);
      await_lvl(0, 10'd160, 16);
      wr(IDX_RVOL, 8'h7f);
      await_lvl(1, 10'd1016, 16);
      rd_chk("left volume", IDX_LVOL, 8'h14);
   endtask
   task automatic t_mute();
      wr(IDX_LVOL, 8'h94);
      chk("pins one muted", 32'({pin_l_n, pin_r_n}), 32'h1);
      chk("common mode", 32'(cm_hold), 32'h1);
      await_lvl(0, LVL_MUTE, 16);
      repeat (2) @(posedge clk);
      chk("silenced", 32'({sil_l, sil_r}), 32'h2);
      wr(IDX_MODE2, 8'h0a);
      wr(IDX_RVOL, 8'hff);
      chk("pins combined", 32'({pin_l_n, pin_r_n}), 32'h0);
      wr(IDX_LVOL, 8'h00);
      wr(IDX_RVOL, 8'h00);
      chk("pins released", 32'({pin_l_n, pin_r_n, cm_hold}), 32'h6);
      wr(IDX_MODE2, 8'h02);
   endtask
   task automatic t_freeze();
      wr(IDX_MODE2, 8'h06);
      wr(IDX_CAPCTL, 8'h20);
      wr(IDX_LVOL, 8'h05);
      chk("frozen capture", 32'({dith, fmt, cm_r, cm_l, hpf_r, hpf_l}), 32'h15);
      chk("frozen level", 32'(l_lvl), 32'h0);
      rd_chk("stored capture", IDX_CAPCTL, 8'h20);
      wr(IDX_MODE2, 8'h02);
      chk("released capture", 32'({dith, fmt, cm_r, cm_l, hpf_r, hpf_l}), 32'h20);
      await_lvl(0, 10'd40, 16);
   endtask
   task automatic t_level_modes();
      wr(IDX_MIXCTL, 8'h10);
      wr(IDX_LVOL, 8'h0a);
      wr(IDX_RVOL, 8'h0a);
      repeat (20) @(posedge clk);
      chk("waiting for crossing", 32'(l_lvl), 32'd40);
      pulse(1, 1);
      await_lvl(0, 10'd80, 16);
      chk("right waits alone", 32'(r_lvl), 32'h0);
      pulse(2, 1);
      await_lvl(1, 10'd80, 16);
      wr(IDX_MIXCTL, 8'h20);
      wr(IDX_LVOL, 8'h0b);
      pulse(0, 4);
      chk("ramp midway", 32'(l_lvl), 32'd84);
      pulse(0, 4);
      await_lvl(0, 10'd88, 8);
      pulse(0, 2);
      chk("ramp holds target", 32'(l_lvl), 32'd88);
      wr(IDX_MIXCTL, 8'h30);
      wr(IDX_LVOL, 8'h0c);
      pulse(0, 2);
      chk("both waits", 32'(l_lvl), 32'd88);
      pulse(1, 1);
      await_lvl(0, 10'd89, 16);
      wr(IDX_MIXCTL, 8'h10);
      pulse(0, 511);
      chk("no early forced change", 32'(l_lvl), 32'd89);
      pulse(0, 1);
      await_lvl(0, 10'd96, 16);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out();
   end
   initial begin
      resetn = 1'b0;
      fsync = 1'b0;
      zc_l = 1'b0;
      zc_r = 1'b0;
      bad_count = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_capture();
      t_mode();
      t_volume();
      t_mute();
      t_freeze();
      t_level_modes();
      close_out();
   end
endmodule // cvr_regs_bench
